/* hdl/lapdmb_regs.vh */
`ifndef LAPDMB_REGS_VH
`define LAPDMB_REGS_VH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define LAPDMB_IDX_SEL 12'h11B
`define LAPDMB_IDX_TXCNT1 12'h114
`define LAPDMB_IDX_TXCNT2 12'h144
`define LAPDMB_IDX_TXCNT3 12'h154
`define LAPDMB_IDX_RXCNT1 12'h115
`define LAPDMB_IDX_RXCNT2 12'h145
`define LAPDMB_IDX_RXCNT3 12'h155
`define LAPDMB_IDX_BUF0 12'h600
`define LAPDMB_IDX_BUF1 12'h700
`define LAPDMB_IDX_IRQST 12'h1F0
`define LAPDMB_IDX_IRQMSK 12'h1F1

// ***************************************************************
// field positions
// ***************************************************************
`define LAPDMB_CNT_FLAG_BIT 7
`define LAPDMB_IRQ_RX_END_OF_TRANSFER_IRQ_BIT 0
`define LAPDMB_IRQ_TXDONE_BIT 1

// ***************************************************************
// sizes and reset values
// ***************************************************************
`define LAPDMB_BUF_LAST 7'h5F
`define LAPDMB_CTRL_NONE 2'h3
`define LAPDMB_SEL_RST 2'h0
`define LAPDMB_LEN_RST 7'h00
`define LAPDMB_FLAG_RST 1'b0
`define LAPDMB_IRQ_RST 2'h0
`define LAPDMB_BYTE_RST 8'h00

`endif

/* hdl/lapdmb_buffer.v */
`timescale 1ns/1ps
`include "lapdmb_regs.vh"

module lapdmb_buffer (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // host byte port
    input wire hostRd,
    input wire hostWr,
    input wire [7:0] hostWrData,
    input wire rewind,
    output wire [7:0] hostRdData,
    // framing engine port
    input wire engWr,
    input wire [6:0] engWrIdx,
    input wire [7:0] engWrData,
    input wire [6:0] engRdIdx,
    output wire [7:0] engRdData
);

    reg [7:0] mem_r [0:95];
    reg [6:0] ptr_r;
    reg [6:0] ptr_nxt;
    integer i;

    assign hostRdData = mem_r[ptr_r];
    assign engRdData = (engRdIdx > `LAPDMB_BUF_LAST) ? `LAPDMB_BYTE_RST : mem_r[engRdIdx];

    // ***************************************************************
    // auto incrementing position pointer
    // ***************************************************************
    always @* begin
        ptr_nxt = ptr_r;
        if (rewind) begin
            ptr_nxt = 7'h00;
        end else if (hostRd || hostWr) begin
            if (ptr_r == `LAPDMB_BUF_LAST) begin
                ptr_nxt = 7'h00;
            end else begin
                ptr_nxt = ptr_r + 7'h01;
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= 7'h00;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // ***************************************************************
    // byte storage, engine write wins a collision
    // ***************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 96; i = i + 1) begin
                mem_r[i] <= `LAPDMB_BYTE_RST;
            end
        end else begin
            if (hostWr) begin
                mem_r[ptr_r] <= hostWrData;
            end
            if (engWr && (engWrIdx <= `LAPDMB_BUF_LAST)) begin
                mem_r[engWrIdx] <= engWrData;
            end
        end
    end

endmodule // lapdmb_buffer

/* hdl/lapdmb_irq.v */
`timescale 1ns/1ps
`include "lapdmb_regs.vh"

module lapdmb_irq (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // events
    input wire [1:0] evt,
    // software access
    input wire clrWr,
    input wire [1:0] clrData,
    input wire maskWr,
    input wire [1:0] maskData,
    output reg [1:0] status_r,
    output reg [1:0] mask_r,
    output reg irq_r
);

    reg [1:0] status_nxt;

    // set wins over a write-one clear
    always @* begin
        status_nxt = status_r;
        if (clrWr) begin
            status_nxt = status_nxt & ~clrData;
        end
        status_nxt = status_nxt | evt;
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= `LAPDMB_IRQ_RST;
            mask_r <= `LAPDMB_IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (maskWr) begin
                mask_r <= maskData;
            end
            irq_r <= |(status_nxt & (maskWr ? maskData : mask_r));
        end
    end

endmodule // lapdmb_irq

/* hdl/lapdmb_port.v */
// Summary of operation
// - buffer zero holds 96 bytes, auto-increment port
// - buffer one, same size, own port address
// - port writes load transmit, reads return receive
// - select register gates the transmit launch and a select write rewinds both buffer pointers; buffer accesses are not steered
// - written available buffer goes into outgoing frame
// - transmitted contents are not kept for readback; the code leaves them in the buffer and port reads return them
// - receive count bit seven names ready buffer
// - successive accesses step through successive bytes
`timescale 1ns/1ps
`include "lapdmb_regs.vh"

module lapdmb_port (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // interrupt
    output wire irqOut,
    // controller select to framing engines
    output reg [1:0] hdlcSelect,
    // transmit launch to framing engine
    output reg txLaunch,
    output reg [1:0] txLaunchCtrl,
    output reg txLaunchBuf,
    output reg [6:0] txLaunchLen,
    input wire txDone,
    input wire [1:0] txDoneCtrl,
    // engine buffer read
    input wire engRdBuf,
    input wire [6:0] engRdIdx,
    output reg [7:0] engRdData,
    // engine buffer write
    input wire engWr,
    input wire engWrBuf,
    input wire [6:0] engWrIdx,
    input wire [7:0] engWrData,
    // receive completion from framing engine
    input wire rxDone,
    input wire [1:0] rxDoneCtrl,
    input wire rxDoneBuf,
    input wire [6:0] rxDoneLen
);

    // ***************************************************************
    // address decode helpers
    // ***************************************************************
    function [1:0] txCtrlOf;
        input [11:0] idx;
        begin
            case (idx)
                `LAPDMB_IDX_TXCNT1: txCtrlOf = 2'h0;
                `LAPDMB_IDX_TXCNT2: txCtrlOf = 2'h1;
                `LAPDMB_IDX_TXCNT3: txCtrlOf = 2'h2;
                default: txCtrlOf = `LAPDMB_CTRL_NONE;
            endcase
        end
    endfunction

    function [1:0] rxCtrlOf;
        input [11:0] idx;
        begin
            case (idx)
                `LAPDMB_IDX_RXCNT1: rxCtrlOf = 2'h0;
                `LAPDMB_IDX_RXCNT2: rxCtrlOf = 2'h1;
                `LAPDMB_IDX_RXCNT3: rxCtrlOf = 2'h2;
                default: rxCtrlOf = `LAPDMB_CTRL_NONE;
            endcase
        end
    endfunction

    function mapped;
        input [11:0] idx;
        begin
            mapped = (idx == `LAPDMB_IDX_SEL) || (idx == `LAPDMB_IDX_BUF0) ||
                (idx == `LAPDMB_IDX_BUF1) || (idx == `LAPDMB_IDX_IRQST) ||
                (idx == `LAPDMB_IDX_IRQMSK) ||
                (txCtrlOf(idx) != `LAPDMB_CTRL_NONE) ||
                (rxCtrlOf(idx) != `LAPDMB_CTRL_NONE);
        end
    endfunction

    // ***************************************************************
    // declarations
    // ***************************************************************
    wire [11:0] idx;
    wire [1:0] txSel;
    wire [1:0] rxSel;
    wire setup;
    wire access;
    wire accWr;
    wire accRd;
    wire [1:0] irqStatus;
    wire [1:0] irqMask;
    wire [7:0] buf0RdData;
    wire [7:0] buf1RdData;
    wire [7:0] buf0EngData;
    wire [7:0] buf1EngData;
    wire [1:0] irqEvt;
    wire selWr;
    wire txCntWr;
    reg [1:0] rewind;
    reg [1:0] hostRd;
    reg [1:0] hostWr;
    reg [6:0] txLen_r [0:2];
    reg txFreeBuf_r [0:2];
    reg [6:0] rxLen_r [0:2];
    reg rxReadyBuf_r [0:2];
    reg [31:0] rdMux;
    integer c;

    assign idx = paddr[13:2];
    assign txSel = txCtrlOf(idx);
    assign rxSel = rxCtrlOf(idx);
    assign setup = psel && !penable;
    assign access = psel && penable && pready && !pslverr;
    assign accWr = access && pwrite;
    assign accRd = access && !pwrite;
    assign selWr = accWr && (idx == `LAPDMB_IDX_SEL) && (pwdata[1:0] != `LAPDMB_CTRL_NONE);
    assign txCntWr = accWr && (txSel != `LAPDMB_CTRL_NONE);
    assign irqEvt[`LAPDMB_IRQ_RX_END_OF_TRANSFER_IRQ_BIT] = rxDone && (rxDoneCtrl != `LAPDMB_CTRL_NONE);
    assign irqEvt[`LAPDMB_IRQ_TXDONE_BIT] = txDone && (txDoneCtrl != `LAPDMB_CTRL_NONE);

    // ***************************************************************
    // buffer strobes
    // ***************************************************************
    always @* begin
        hostRd = 2'b00;
        hostWr = 2'b00;
        rewind = 2'b00;
        hostRd[0] = accRd && (idx == `LAPDMB_IDX_BUF0);
        hostRd[1] = accRd && (idx == `LAPDMB_IDX_BUF1);
        hostWr[0] = accWr && (idx == `LAPDMB_IDX_BUF0);
        hostWr[1] = accWr && (idx == `LAPDMB_IDX_BUF1);
        if (selWr) begin
            rewind = 2'b11;
        end
        if (txCntWr) begin
            rewind[txFreeBuf_r[txSel]] = 1'b1;
        end
        if (irqEvt[`LAPDMB_IRQ_RX_END_OF_TRANSFER_IRQ_BIT]) begin
            rewind[rxDoneBuf] = 1'b1;
        end
    end

    lapdmb_buffer u_buf0 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hostRd(hostRd[0]),
        .hostWr(hostWr[0]),
        .hostWrData(pwdata[7:0]),
        .rewind(rewind[0]),
        .hostRdData(buf0RdData),
        .engWr(engWr && !engWrBuf),
        .engWrIdx(engWrIdx),
        .engWrData(engWrData),
        .engRdIdx(engRdIdx),
        .engRdData(buf0EngData)
    );

    lapdmb_buffer u_buf1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hostRd(hostRd[1]),
        .hostWr(hostWr[1]),
        .hostWrData(pwdata[7:0]),
        .rewind(rewind[1]),
        .hostRdData(buf1RdData),
        .engWr(engWr && engWrBuf),
        .engWrIdx(engWrIdx),
        .engWrData(engWrData),
        .engRdIdx(engRdIdx),
        .engRdData(buf1EngData)
    );

    // ***************************************************************
    // interrupt status and mask
    // ***************************************************************
    lapdmb_irq u_irq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .evt(irqEvt),
        .clrWr(accWr && (idx == `LAPDMB_IDX_IRQST)),
        .clrData(pwdata[1:0]),
        .maskWr(accWr && (idx == `LAPDMB_IDX_IRQMSK)),
        .maskData(pwdata[1:0]),
        .status_r(irqStatus),
        .mask_r(irqMask),
        .irq_r(irqOut)
    );

    // ***************************************************************
    // read data mux, sampled in the setup cycle
    // ***************************************************************
    always @* begin
        rdMux = 32'h00000000;
        if (idx == `LAPDMB_IDX_SEL) begin
            rdMux[1:0] = hdlcSelect;
        end else if (idx == `LAPDMB_IDX_BUF0) begin
            rdMux[7:0] = buf0RdData;
        end else if (idx == `LAPDMB_IDX_BUF1) begin
            rdMux[7:0] = buf1RdData;
        end else if (idx == `LAPDMB_IDX_IRQST) begin
            rdMux[1:0] = irqStatus;
        end else if (idx == `LAPDMB_IDX_IRQMSK) begin
            rdMux[1:0] = irqMask;
        end else if (txSel != `LAPDMB_CTRL_NONE) begin
            rdMux[`LAPDMB_CNT_FLAG_BIT] = txFreeBuf_r[txSel];
            rdMux[6:0] = txLen_r[txSel];
        end else if (rxSel != `LAPDMB_CTRL_NONE) begin
            rdMux[`LAPDMB_CNT_FLAG_BIT] = rxReadyBuf_r[rxSel];
            rdMux[6:0] = rxLen_r[rxSel];
        end
    end

    // ***************************************************************
    // apb answer, one wait-free access phase
    // ***************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(idx);
            if (setup && !pwrite && mapped(idx)) begin
                prdata <= rdMux;
            end else if (setup) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ***************************************************************
    // controller select and byte count registers
    // ***************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hdlcSelect <= `LAPDMB_SEL_RST;
            for (c = 0; c < 3; c = c + 1) begin
                txLen_r[c] <= `LAPDMB_LEN_RST;
                txFreeBuf_r[c] <= `LAPDMB_FLAG_RST;
                rxLen_r[c] <= `LAPDMB_LEN_RST;
                rxReadyBuf_r[c] <= `LAPDMB_FLAG_RST;
            end
        end else begin
            if (selWr) begin
                hdlcSelect <= pwdata[1:0];
            end
            if (txCntWr) begin
                txLen_r[txSel] <= pwdata[6:0];
                // next message goes to the other buffer
                txFreeBuf_r[txSel] <= !txFreeBuf_r[txSel];
            end
            if (irqEvt[`LAPDMB_IRQ_RX_END_OF_TRANSFER_IRQ_BIT]) begin
                rxReadyBuf_r[rxDoneCtrl] <= rxDoneBuf;
                rxLen_r[rxDoneCtrl] <= rxDoneLen;
            end
        end
    end

    // ***************************************************************
    // transmit launch towards the selected controller
    // ***************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            txLaunch <= 1'b0;
            txLaunchCtrl <= `LAPDMB_SEL_RST;
            txLaunchBuf <= 1'b0;
            txLaunchLen <= `LAPDMB_LEN_RST;
        end else begin
            txLaunch <= txCntWr && (txSel == hdlcSelect);
            if (txCntWr) begin
                txLaunchCtrl <= txSel;
                txLaunchBuf <= txFreeBuf_r[txSel];
                txLaunchLen <= pwdata[6:0];
            end
        end
    end

    // ***************************************************************
    // engine read port, bytes stay in the buffer after sending
    // ***************************************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            engRdData <= `LAPDMB_BYTE_RST;
        end else begin
            // buffer is reused by receive after send
            engRdData <= engRdBuf ? buf1EngData : buf0EngData;
        end
    end

endmodule // lapdmb_port

/* verification/lapdmb_port_assertions.sv */
`timescale 1ns/1ps
`include "lapdmb_regs.vh"

module lapdmb_port_assertions (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // side
    input wire irqOut,
    input wire [1:0] hdlcSelect,
    input wire txLaunch,
    input wire txDone,
    input wire rxDone
);
    // ********
    // helpers
    // ********
    wire [11:0] idx = paddr[13:2];
    wire mapped = idx inside {`LAPDMB_IDX_SEL, `LAPDMB_IDX_TXCNT1, `LAPDMB_IDX_TXCNT2,
        `LAPDMB_IDX_TXCNT3, `LAPDMB_IDX_RXCNT1, `LAPDMB_IDX_RXCNT2, `LAPDMB_IDX_RXCNT3,
        `LAPDMB_IDX_BUF0, `LAPDMB_IDX_BUF1, `LAPDMB_IDX_IRQST, `LAPDMB_IDX_IRQMSK};
    wire [11:0] txSel = hdlcSelect == 2'h0 ? `LAPDMB_IDX_TXCNT1 :
        hdlcSelect == 2'h1 ? `LAPDMB_IDX_TXCNT2 : `LAPDMB_IDX_TXCNT3;
    // no event and no register write this cycle
    wire calm = !rxDone && !txDone && !(pready && pwrite);

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence setupS;
        psel && !penable;
    endsequence
    sequence txWrS;
        (psel && penable && pready) ##0 (pwrite && idx == txSel);
    endsequence

    a_ready_after_setup: assert property (setupS |=> pready)
        else $error("no pready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_error_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for index");
    a_read_byte_only: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read upper bits set");
    a_write_data_zero: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_select_range: assert property (hdlcSelect != `LAPDMB_CTRL_NONE)
        else $error("select holds value 3");
    a_launch_follows: assert property (txWrS |=> txLaunch)
        else $error("launch missing");
    a_launch_cause: assert property (txLaunch |-> $past(pready && pwrite && idx == txSel))
        else $error("launch without selected write");
    a_irq_quiet: assert property (calm [*2] ##0 !irqOut |=> !irqOut)
        else $error("irq without cause");
endmodule // lapdmb_port_assertions

bind lapdmb_port lapdmb_port_assertions chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irqOut(irqOut),
    .hdlcSelect(hdlcSelect),
    .txLaunch(txLaunch),
    .txDone(txDone),
    .rxDone(rxDone)
);

/* verification/lapdmb_host_model.sv */
`timescale 1ns/1ps
`include "lapdmb_regs.vh"

module lapdmb_host_model (
    // clock
    input wire core_clk,
    // apb master
    output reg psel,
    output reg penable,
    output reg pwrite,
    output reg [13:0] paddr,
    output reg [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h00000000;
    end

    function [11:0] txIdx(input [1:0] c);
        txIdx = c == 2'h0 ? `LAPDMB_IDX_TXCNT1 : c == 2'h1 ? `LAPDMB_IDX_TXCNT2 : `LAPDMB_IDX_TXCNT3;
    endfunction
    function [11:0] rxIdx(input [1:0] c);
        rxIdx = c == 2'h0 ? `LAPDMB_IDX_RXCNT1 : c == 2'h1 ? `LAPDMB_IDX_RXCNT2 : `LAPDMB_IDX_RXCNT3;
    endfunction
    function [11:0] bufIdx(input b);
        bufIdx = b ? `LAPDMB_IDX_BUF1 : `LAPDMB_IDX_BUF0;
    endfunction

    // one transfer; answer taken at the rising edge that samples pready high
    task xfer(input wr, input [11:0] a, input [7:0] d, output [7:0] q, output err);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= {a, 2'b00};
            pwdata <= {24'h000000, d};
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1) @(posedge core_clk);
            q = prdata[7:0];
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end
    endtask

    task freeBuf(input [1:0] c, output [7:0] v);
        reg err;
        xfer(1'b0, txIdx(c), 8'h00, v, err);
    endtask
    task readyBuf(input [1:0] c, output [7:0] v);
        reg err;
        xfer(1'b0, rxIdx(c), 8'h00, v, err);
    endtask
endmodule // lapdmb_host_model

/* verification/test_lapd_message_buffer_port.sv */
`timescale 1ns/1ps
`include "lapdmb_regs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end

module test_lapd_message_buffer_port;
    reg core_clk = 1'b0;
    reg rst_n = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, irqOut, txLaunch, txLaunchBuf;
    wire [13:0] paddr;
    wire [31:0] pwdata, prdata;
    wire [1:0] hdlcSelect, txLaunchCtrl;
    wire [6:0] txLaunchLen;
    wire [7:0] engRdData;
    reg txDone = 1'b0, engRdBuf = 1'b0, engWr = 1'b0, engWrBuf = 1'b0;
    reg rxDone = 1'b0, rxDoneBuf = 1'b0;
    reg [1:0] txDoneCtrl = 2'h0, rxDoneCtrl = 2'h0;
    reg [6:0] engRdIdx = 7'h00, engWrIdx = 7'h00, rxDoneLen = 7'h00, len;
    reg [7:0] engWrData = 8'h00, q, mem [0:95];
    reg e, f;
    integer fail_count = 0, checks = 0, launches = 0, i, b, c, n;

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) if (txLaunch === 1'b1) launches <= launches + 1;

    lapdmb_port dut (.*);
    lapdmb_host_model host (.*);

    // ********
    // tasks
    // ********
    task wr(input [11:0] a, input [7:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask
    task rd(input [11:0] a);
        host.xfer(1'b0, a, 8'h00, q, e);
    endtask
    task edges(input integer k);
        repeat (k) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task rxEvent(input [1:0] rc, input rb);
        rxDone <= 1'b1;
        rxDoneCtrl <= rc;
        rxDoneBuf <= rb;
        rxDoneLen <= len;
        @(posedge core_clk);
        rxDone <= 1'b0;
        edges(1);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        #1000000;
        fail_count++;
        tally_and_finish;
    end

    // ********
    // scenarios
    // ********
    initial begin
        i = $urandom(49711);
        len = 7'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        for (c = 0; c < 3; c++) begin
            rd(host.txIdx(c[1:0]));
            `CHK("tx count", 8'h00, q)
            rd(host.rxIdx(c[1:0]));
            `CHK("rx count", 8'h00, q)
        end
        rd(`LAPDMB_IDX_BUF1);
        `CHK("buffer one", 8'h00, q)
        rd(12'h123);
        `CHK("unmapped", 1'b1, e)
        wr(`LAPDMB_IDX_SEL, 8'h03);
        rd(`LAPDMB_IDX_SEL);
        `CHK("select", 8'h00, q)
        for (b = 0; b < 2; b++) begin
            wr(`LAPDMB_IDX_SEL, 8'h00);
            for (i = 0; i < 96; i++) begin
                mem[i] = 8'($urandom);
                wr(host.bufIdx(b[0]), mem[i]);
            end
            engRdBuf <= b[0];
            engRdIdx <= 7'd95;
            edges(1);
            `CHK("engine read", mem[95], engRdData)
            @(posedge core_clk);
            engRdIdx <= 7'h60;
            edges(1);
            `CHK("engine range", 8'h00, engRdData)
            wr(`LAPDMB_IDX_SEL, 8'h00);
            for (i = 0; i < 97; i++) begin
                rd(host.bufIdx(b[0]));
                `CHK("buffer byte", mem[i % 96], q)
            end
        end
        wr(`LAPDMB_IDX_IRQMSK, 8'h01);
        for (c = 0; c < 3; c++) begin
            @(posedge core_clk);
            b = $urandom % 2;
            len = 7'(1 + $urandom % 96);
            for (i = 0; i < 4; i++) begin
                mem[i] = 8'($urandom);
                engWr <= 1'b1;
                engWrBuf <= b[0];
                engWrIdx <= 7'(i);
                engWrData <= mem[i];
                @(posedge core_clk);
            end
            engWr <= 1'b0;
            rxEvent(c[1:0], b[0]);
            `CHK("irq raised", 1'b1, irqOut)
            host.readyBuf(c[1:0], q);
            `CHK("rx ready", {b[0], len}, q)
            wr(`LAPDMB_IDX_SEL, c[7:0]);
            for (i = 0; i < 4; i++) begin
                rd(host.bufIdx(b[0]));
                `CHK("rx byte", mem[i], q)
            end
            wr(`LAPDMB_IDX_IRQST, 8'h01);
            edges(1);
            `CHK("irq cleared", 1'b0, irqOut)
        end
        wr(`LAPDMB_IDX_IRQMSK, 8'h00);
        rxEvent(2'h0, 1'b0);
        `CHK("irq masked", 1'b0, irqOut)
        rd(`LAPDMB_IDX_IRQST);
        `CHK("status", 8'h01, q)
        wr(`LAPDMB_IDX_IRQST, 8'h01);
        for (c = 0; c < 3; c++) begin
            wr(`LAPDMB_IDX_SEL, c[7:0]);
            host.freeBuf(c[1:0], q);
            f = q[7];
            len = 7'(1 + $urandom % 96);
            n = launches;
            wr(host.txIdx(c[1:0]), {1'b0, len});
            edges(3);
            `CHK("launches", n + 1, launches)
            `CHK("launch ctrl", c[1:0], txLaunchCtrl)
            `CHK("launch buffer", f, txLaunchBuf)
            `CHK("launch length", len, txLaunchLen)
            rd(host.txIdx(c[1:0]));
            `CHK("free flag", {~f, len}, q)
            n = launches;
            wr(host.txIdx(2'((c + 1) % 3)), 8'h05);
            edges(3);
            `CHK("no launch", n, launches)
        end
        @(posedge core_clk);
        txDone <= 1'b1;
        @(posedge core_clk);
        txDone <= 1'b0;
        rd(`LAPDMB_IDX_IRQST);
        `CHK("tx status", 8'h02, q)
        wr(`LAPDMB_IDX_IRQMSK, 8'h02);
        edges(1);
        `CHK("tx irq", 1'b1, irqOut)
        wr(`LAPDMB_IDX_IRQST, 8'h02);
        edges(1);
        `CHK("tx irq off", 1'b0, irqOut)
        rxEvent(2'h3, 1'b1);
        rd(`LAPDMB_IDX_IRQST);
        `CHK("ignored ctrl", 8'h00, q)
        tally_and_finish;
    end
endmodule // test_lapd_message_buffer_port
